// *** hw/serdes_test_regs.sv ***
// What this block does
// - ethernet mode: comma plus data character classifies as idle, busy aside
// - ethernet mode: transmit idle uses D5.6 instead of D15.2
// - effective ethernet mode is register bit or mode pin
// - busy pass bit or pin: K28.5 D10.1 passes as data, else idle
// - busy pass setting only counts while ethernet mode active
// - check enable turns on pattern checking, results in pattern status high byte
// - generate enable starts patterns on the transmit serial words; receive bus sees them only in serial loopback
// - global emphasis field two bits, resets to 11
// - receive soft reset bit resets both pattern generator and checker of its lane
// - transmit soft reset bit resets both pattern generator and checker of its lane
// - soft reset bits clear themselves on the next mdc cycle
// - pattern status high byte gives read-only receive pass flags
// - serial loopback by pin or per channel, receive reflects transmit input
// - serial loopback tristates serial outputs
// - serial loopback ignores serial receive input
// - far-end loopback retransmits serial input, parallel side ignored/tristated
// - power-on reset tristates receive data and holds receive clocks low
// - self-test makes 127-long pattern into the 10-bit transmit register
// - self-test enabled by pin or register bit
// - self-test ignores parallel transmit data
// - each serial loopback bit is ored with loopback pin
// - far-end loopback only on pairs A/B, C/D, E/F, G/H
//
// management register bank and test data paths of an eight-lane serdes
// assumes mdc and mdio pins are asynchronous and slow against clk_in
module serdes_test_regs
   import serdes_test_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic por_active_in,
   // management pins
   input wire logic mdc_in,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe_n_out,
   input wire logic [4:0] phy_addr_in,
   // mode pins
   input wire logic ethernet_mode_pin_in,
   input wire logic busy_pass_pin_in,
   input wire logic alt_busy_pin_in,
   input wire logic pattern_test_pin_in,
   input wire logic loopback_pin_in,
   // per-lane parallel side, word strobe from core logic
   input wire logic word_stb_in,
   input wire logic [NUM_CH*WORD_W-1:0] tx_parallel_bus_in,
   output logic [NUM_CH*WORD_W-1:0] rx_parallel_bus_out,
   output logic [NUM_CH-1:0] rx_parallel_oe_n_out,
   output logic [NUM_CH-1:0] rx_clk_out,
   // per-lane serial side, words before serialiser / after deserialiser
   input wire logic [NUM_CH*WORD_W-1:0] rx_serial_word_in,
   output logic [NUM_CH*WORD_W-1:0] tx_serial_word_out,
   output logic [NUM_CH-1:0] tx_serial_oe_n_out,
   // receive classification
   output logic [NUM_CH-1:0] rx_idle_out,
   // global controls
   output logic rate_comp_enable_out,
   output logic [1:0] emphasis_level_global_out,
   output logic [NUM_CH-1:0] rx_chan_soft_reset_out,
   output logic [NUM_CH-1:0] tx_chan_soft_reset_out
);
   typedef enum {ST_IDLE, ST_HDR, ST_TA, ST_WDATA, ST_RDATA} mdio_state_t;

   // pin synchronisers
   logic [1:0] mdc_s_q, mdio_s_q;
   logic mdc_old_q;
   logic gige_p_q1, gige_p_q, busy_p_q1, busy_p_q, alt_p_q1, alt_p_q;
   logic prbs_p_q1, prbs_p_q, loopback_pin_p_q1, loopback_pin_p_q;
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         mdc_s_q <= '0;
         mdio_s_q <= '0;
         mdc_old_q <= 1'b0;
         {gige_p_q1, gige_p_q, busy_p_q1, busy_p_q, alt_p_q1, alt_p_q} <= '0;
         {prbs_p_q1, prbs_p_q, loopback_pin_p_q1, loopback_pin_p_q} <= '0;
      end else begin
         mdc_s_q <= {mdc_s_q[0], mdc_in};
         mdio_s_q <= {mdio_s_q[0], mdio_in};
         mdc_old_q <= mdc_s_q[1];
         gige_p_q1 <= ethernet_mode_pin_in;
         gige_p_q <= gige_p_q1;
         busy_p_q1 <= busy_pass_pin_in;
         busy_p_q <= busy_p_q1;
         alt_p_q1 <= alt_busy_pin_in;
         alt_p_q <= alt_p_q1;
         prbs_p_q1 <= pattern_test_pin_in;
         prbs_p_q <= prbs_p_q1;
         loopback_pin_p_q1 <= loopback_pin_in;
         loopback_pin_p_q <= loopback_pin_p_q1;
      end
   end
   logic mdc_rise, mdc_fall;
   assign mdc_rise = mdc_s_q[1] && !mdc_old_q;
   assign mdc_fall = !mdc_s_q[1] && mdc_old_q;

   // registers
   logic [15:0] global_q, factory_q, loop_q;
   logic [NUM_CH-1:0] rx_srst_q, tx_srst_q;
   logic [NUM_CH-1:0] pass_w;

   // mdio frame engine
   mdio_state_t st_q;
   logic [5:0] cnt_q;
   logic [13:0] hdr_q;
   logic [15:0] sh_q;
   logic [4:0] reg_q;
   logic rd_q, mine_q;
   logic wr_stb;
   assign wr_stb = mdc_rise && st_q == ST_WDATA && cnt_q == 6'd15 && mine_q;

   function automatic logic [15:0] read_word(input logic [4:0] a);
      if (a == REG_GLOBAL_CTRL) begin
         return global_q;
      end else if (a == REG_LOOP) begin
         return loop_q;
      end else if (a == REG_SOFT_RESET) begin
         return {rx_srst_q, tx_srst_q};
      end else if (a == REG_FACTORY) begin
         return factory_q;
      end else if (a == REG_PATTERN) begin
         return {pass_w, 8'h00};
      end else begin
         return 16'h0000;
      end
   endfunction

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_q <= ST_IDLE;
         cnt_q <= '0;
         hdr_q <= '0;
         sh_q <= '0;
         reg_q <= '0;
         rd_q <= 1'b0;
         mine_q <= 1'b0;
      end else if (mdc_rise) begin
         case (st_q)
            ST_IDLE: begin
               cnt_q <= mdio_s_q[1] ? cnt_q + ((cnt_q == 6'd32) ? 6'd0 : 6'd1) : 6'd0;
               if (cnt_q == 6'd32 && !mdio_s_q[1]) begin
                  st_q <= ST_HDR;
                  cnt_q <= 6'd1;
                  hdr_q <= '0;
               end
            end
            ST_HDR: begin
               hdr_q <= {hdr_q[12:0], mdio_s_q[1]};
               cnt_q <= cnt_q + 6'd1;
               if (cnt_q == 6'd13) begin
                  st_q <= ST_TA;
                  cnt_q <= '0;
                  rd_q <= hdr_q[10:9] == 2'b10;
                  mine_q <= hdr_q[8:4] == phy_addr_in;
                  reg_q <= {hdr_q[3:0], mdio_s_q[1]};
               end
            end
            ST_TA: begin
               cnt_q <= cnt_q + 6'd1;
               if (cnt_q == 6'd1) begin
                  st_q <= rd_q ? ST_RDATA : ST_WDATA;
                  cnt_q <= '0;
                  sh_q <= read_word(reg_q);
               end
            end
            ST_WDATA: begin
               sh_q <= {sh_q[14:0], mdio_s_q[1]};
               cnt_q <= cnt_q + 6'd1;
               if (cnt_q == 6'd15) begin
                  st_q <= ST_IDLE;
                  cnt_q <= '0;
               end
            end
            ST_RDATA: begin
               sh_q <= {sh_q[14:0], 1'b0};
               cnt_q <= cnt_q + 6'd1;
               if (cnt_q == 6'd15) begin
                  st_q <= ST_IDLE;
                  cnt_q <= '0;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // read data launched on falling mdc
   logic drive_q;
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         drive_q <= 1'b0;
         mdio_out <= 1'b1;
      end else if (mdc_fall) begin
         drive_q <= st_q == ST_RDATA && mine_q;
         mdio_out <= sh_q[15];
      end
   end
   assign mdio_oe_n_out = !drive_q;

   logic [15:0] wr_word;
   assign wr_word = {sh_q[14:0], mdio_s_q[1]};

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         global_q <= RST_GLOBAL_CTRL;
         factory_q <= RST_FACTORY;
         loop_q <= RST_LOOP;
      end else if (wr_stb) begin
         if (reg_q == REG_GLOBAL_CTRL) begin
            global_q <= wr_word & GLOBAL_RW_MASK;
         end else if (reg_q == REG_FACTORY) begin
            factory_q <= wr_word & FACTORY_RW_MASK;
         end else if (reg_q == REG_LOOP) begin
            loop_q <= wr_word;
         end
      end
   end

   // soft resets: held one mdc cycle, cleared at the next mdc rise
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rx_srst_q <= '0;
         tx_srst_q <= '0;
      end else if (wr_stb && reg_q == REG_SOFT_RESET) begin
         rx_srst_q <= wr_word[15:8];
         tx_srst_q <= wr_word[7:0];
      end else if (mdc_rise) begin
         rx_srst_q <= '0;
         tx_srst_q <= '0;
      end
   end
   assign rx_chan_soft_reset_out = rx_srst_q;
   assign tx_chan_soft_reset_out = tx_srst_q;

   // effective modes
   logic gige_eff, busy_eff, gen_eff, check_eff;
   logic [NUM_CH-1:0] sloop, floop;
   assign gige_eff = global_q[BIT_GIGE] | gige_p_q;
   assign busy_eff = gige_eff & (global_q[BIT_BUSY] | busy_p_q);
   assign gen_eff = global_q[BIT_GEN] | prbs_p_q;
   assign check_eff = global_q[BIT_CHECK];
   assign sloop = loop_q[15:8] | {NUM_CH{loopback_pin_p_q}};
   assign rate_comp_enable_out = global_q[BIT_RATE];
   assign emphasis_level_global_out = global_q[EMPH_LO+1:EMPH_LO];

   // far-end loopback only as a whole pair
   generate
      for (genvar p = 0; p < NUM_CH/2; p++) begin : g_pair
         assign floop[2*p] = loop_q[2*p] & loop_q[2*p+1];
         assign floop[2*p+1] = loop_q[2*p] & loop_q[2*p+1];
      end
   endgenerate

   // lanes
   logic [NUM_CH*WORD_W-1:0] gen_words;
   logic [NUM_CH*WORD_W-1:0] rx_d, tx_d;
   logic [NUM_CH-1:0] prev_k_q;
   logic [NUM_CH-1:0] tx_k_q;
   logic [NUM_CH-1:0] idle_d;
   generate
      for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
         logic [WORD_W-1:0] txw, rxs, tx_prev;
         assign txw = tx_parallel_bus_in[c*WORD_W +: WORD_W];
         assign rxs = rx_serial_word_in[c*WORD_W +: WORD_W];
         pattern_lane u_lane (
            .clk_in(clk_in),
            .rst_n_in(rst_n_in),
            .chan_reset_in(rx_srst_q[c] | tx_srst_q[c]),
            .gen_en_in(gen_eff),
            .check_en_in(check_eff),
            .word_stb_in(word_stb_in),
            .rx_word_in(sloop[c] ? gen_words[c*WORD_W +: WORD_W] : rxs),
            .gen_word_out(gen_words[c*WORD_W +: WORD_W]),
            .pass_out(pass_w[c])
         );
         always_comb begin
            tx_prev = '0;
            if (floop[c]) begin
               tx_d[c*WORD_W +: WORD_W] = rxs;
            end else if (gen_eff) begin
               tx_d[c*WORD_W +: WORD_W] = gen_words[c*WORD_W +: WORD_W];
            end else if (gige_eff && tx_k_q[c] && txw == D15_2) begin
               tx_d[c*WORD_W +: WORD_W] = D5_6;
            end else begin
               tx_d[c*WORD_W +: WORD_W] = txw;
            end
            rx_d[c*WORD_W +: WORD_W] = sloop[c] ? tx_d[c*WORD_W +: WORD_W] : rxs;
            tx_prev = rx_d[c*WORD_W +: WORD_W];
            idle_d[c] = gige_eff && prev_k_q[c] && tx_prev != K28_5_RDN &&
                        tx_prev != K28_5_RDP &&
                        !((busy_eff || alt_p_q) && tx_prev == D10_1);
         end
      end
   endgenerate

   // data registers; comma history per lane
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         prev_k_q <= '0;
         tx_k_q <= '0;
         rx_parallel_bus_out <= '0;
         tx_serial_word_out <= '0;
         rx_idle_out <= '0;
      end else if (word_stb_in) begin
         for (int c = 0; c < NUM_CH; c++) begin
            prev_k_q[c] <= rx_d[c*WORD_W +: WORD_W] == K28_5_RDN ||
                           rx_d[c*WORD_W +: WORD_W] == K28_5_RDP;
            tx_k_q[c] <= tx_parallel_bus_in[c*WORD_W +: WORD_W] == K28_5_RDN ||
                         tx_parallel_bus_in[c*WORD_W +: WORD_W] == K28_5_RDP;
         end
         rx_parallel_bus_out <= rx_d;
         tx_serial_word_out <= tx_d;
         rx_idle_out <= idle_d;
      end
   end

   assign tx_serial_oe_n_out = sloop;
   assign rx_parallel_oe_n_out = floop | {NUM_CH{por_active_in}};
   assign rx_clk_out = por_active_in ? '0 : {NUM_CH{word_stb_in}};

   AST_SRST_SELF_CLEAR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (rx_srst_q != 0) && mdc_rise |=> rx_srst_q == 0) else $error("soft reset stuck");
   AST_EMPH_RESET: assert property (@(posedge clk_in)
      !rst_n_in |=> emphasis_level_global_out == 2'b11) else $error("emphasis reset");
   AST_SLOOP_TRI: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      loopback_pin_p_q |-> tx_serial_oe_n_out == 8'hFF) else $error("serial out driven");
   AST_POR_CLK: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      por_active_in |-> rx_clk_out == 0 && rx_parallel_oe_n_out == 8'hFF)
      else $error("por outputs");
   AST_BUSY_GATED: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !gige_eff |-> !busy_eff) else $error("busy without ethernet mode");
   AST_PAIR_ONLY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      floop[0] |-> loop_q[1]) else $error("half pair far loop");
   AST_GEN_TX: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      gen_eff && !floop[0] && word_stb_in |=> tx_serial_word_out[9:0] == $past(gen_words[9:0]))
      else $error("pattern not sent");
   AST_LOOP_RX: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      sloop[0] && word_stb_in |=> rx_parallel_bus_out[9:0] == $past(tx_d[9:0]))
      else $error("loopback data");
   COV_READ: cover property (@(posedge clk_in) st_q == ST_RDATA && mine_q);
   COV_WRITE: cover property (@(posedge clk_in) wr_stb);
   COV_PASS: cover property (@(posedge clk_in) pass_w[0]);
endmodule

// *** hw/serdes_test_pkg.sv ***
// shared constants for the serdes test and control register bank
// assumes a clause-22 style mdio frame on mdc, sampled by clk_in
package serdes_test_pkg;
   localparam int NUM_CH = 8;
   localparam int WORD_W = 10;
   localparam logic [4:0] REG_SPARE = 5'h17;
   localparam logic [4:0] REG_GLOBAL_CTRL = 5'h18;
   localparam logic [4:0] REG_RSVD_A = 5'h19;
   localparam logic [4:0] REG_RSVD_SA = 5'h1A;
   localparam logic [4:0] REG_RSVD_SB = 5'h1B;
   localparam logic [4:0] REG_RSVD_SC = 5'h1C;
   localparam logic [4:0] REG_LOOP = 5'h16;
   localparam logic [4:0] REG_SOFT_RESET = 5'h1D;
   localparam logic [4:0] REG_FACTORY = 5'h1E;
   localparam logic [4:0] REG_PATTERN = 5'h1F;
   localparam logic [15:0] RST_GLOBAL_CTRL = 16'h100C;
   localparam logic [15:0] RST_FACTORY = 16'h000B;
   localparam logic [15:0] RST_LOOP = 16'h0000;
   localparam logic [15:0] GLOBAL_RW_MASK = 16'hD30C;
   localparam logic [15:0] FACTORY_RW_MASK = 16'hFF7F;
   localparam int BIT_GIGE = 15;
   localparam int BIT_BUSY = 14;
   localparam int BIT_RATE = 12;
   localparam int BIT_CHECK = 9;
   localparam int BIT_GEN = 8;
   localparam int EMPH_LO = 2;
   localparam logic [4:0] PHY_ADDR_DEF = 5'h00;
   localparam logic [9:0] K28_5_RDN = 10'h0FA;
   localparam logic [9:0] K28_5_RDP = 10'h305;
   localparam logic [9:0] D15_2 = 10'h2E8;
   localparam logic [9:0] D5_6 = 10'h299;
   localparam logic [9:0] D10_1 = 10'h255;
   localparam logic [6:0] LFSR_SEED = 7'h7F;
   localparam logic [3:0] PASS_WORDS = 4'hF;
endpackage

// *** hw/pattern_lane.sv ***
// one channel: 2^7-1 pattern generator and checker on 10-bit words
// assumes the word strobe comes from logic on clk_in
module pattern_lane
   import serdes_test_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // control
   input wire logic chan_reset_in,
   input wire logic gen_en_in,
   input wire logic check_en_in,
   input wire logic word_stb_in,
   // data
   input wire logic [WORD_W-1:0] rx_word_in,
   output logic [WORD_W-1:0] gen_word_out,
   output logic pass_out
);
   logic [6:0] gen_q;
   logic [6:0] chk_q;
   logic [3:0] good_q;

   function automatic logic [16:0] step10(input logic [6:0] s);
      logic [6:0] t;
      logic [9:0] w;
      t = s;
      w = '0;
      for (int i = 0; i < WORD_W; i++) begin
         w = {w[8:0], t[6]};
         t = {t[5:0], t[6] ^ t[5]};
      end
      return {t, w};
   endfunction

   logic [16:0] gen_nx;
   logic [16:0] chk_nx;
   assign gen_nx = step10(gen_q);
   assign chk_nx = step10(chk_q);
   assign gen_word_out = gen_nx[9:0];

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || chan_reset_in || !gen_en_in) begin
         gen_q <= LFSR_SEED;
      end else if (word_stb_in) begin
         gen_q <= gen_nx[16:10];
      end
   end

   // checker self-seeds from received bits, counts clean words; all-zero words never count
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || chan_reset_in || !check_en_in) begin
         chk_q <= LFSR_SEED;
         good_q <= '0;
      end else if (word_stb_in) begin
         // state after this word follows from its last seven bits
         chk_q[6:1] <= rx_word_in[6:1] ^ rx_word_in[5:0];
         chk_q[0] <= rx_word_in[0] ^ rx_word_in[6] ^ rx_word_in[5];
         if (rx_word_in != chk_nx[9:0] || rx_word_in == '0) begin
            good_q <= '0;
         end else if (good_q != PASS_WORDS) begin
            good_q <= good_q + 4'h1;
         end
      end
   end
   assign pass_out = (good_q == PASS_WORDS);

   AST_PASS_NEEDS_CHECK: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      pass_out |-> $past(check_en_in)) else $error("pass without check enable");
endmodule

// *** tb/mdio_station.sv ***
// management station model: frames on mdc/mdio, mdc still between frames
// assumes the bench resolves the shared mdio line with a pull-up
module mdio_station (
   // link pins
   output logic mdc_out,
   output logic mdio_drv_out,
   output logic mdio_en_out,
   // resolved line
   input wire logic mdio_line_in
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      mdc_out = 1'b0;
      mdio_drv_out = 1'b1;
      mdio_en_out = 1'b0;
   end
   // data changes in the low phase, device samples on the rise
   task automatic put_bit(input logic b);
      mdio_en_out = 1'b1;
      mdio_drv_out = b;
      #160 mdc_out = 1'b1;
      #160 mdc_out = 1'b0;
   endtask
   task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rdat);
      logic [13:0] hdr;
      hdr = {2'b01, rd ? 2'b10 : 2'b01, phy, ra};
      rdat = 16'h0000;
      // odd offset keeps mdc out of phase with clk_in
      #7;
      repeat (32) put_bit(1'b1);
      for (int i = 13; i >= 0; i--) put_bit(hdr[i]);
      if (rd) begin
         mdio_en_out = 1'b0;
         repeat (2) begin
            #160 mdc_out = 1'b1;
            #160 mdc_out = 1'b0;
         end
         for (int i = 15; i >= 0; i--) begin
            #160 mdc_out = 1'b1;
            rdat[i] = mdio_line_in;
            #160 mdc_out = 1'b0;
         end
      end else begin
         put_bit(1'b1);
         put_bit(1'b0);
         for (int i = 15; i >= 0; i--) put_bit(wd[i]);
      end
      mdio_en_out = 1'b0;
   endtask
endmodule

// *** tb/serdes_test_control_regs_tb_top.sv ***
// self-checking bench for the serdes test and control register bank
// assumes the station model as mdio master and a pulled-up mdio line
module serdes_test_control_regs_tb_top;
   import serdes_test_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [4:0] phy; logic [4:0] ra; logic [15:0] wd;
      logic [15:0] rexp;} row_t;
   typedef struct packed {logic ge; logic busy; logic [9:0] w2; logic idle;} idle_row_t;
   logic clk_in = 1'b0, rst_n_in = 1'b0, por_active_in = 1'b0, word_stb_in = 1'b0;
   logic ethernet_mode_pin_in = 1'b0, busy_pass_pin_in = 1'b0, pattern_test_pin_in = 1'b0;
   logic loopback_pin_in = 1'b0;
   logic [79:0] tx_parallel_bus_in = '0, rx_serial_word_in = '0;
   logic [79:0] rx_parallel_bus_out, tx_serial_word_out, hist [132];
   logic [7:0] rx_parallel_oe_n_out, rx_clk_out, tx_serial_oe_n_out, rx_idle_out;
   logic [7:0] rx_chan_soft_reset_out, tx_chan_soft_reset_out;
   logic [1:0] emphasis_level_global_out;
   logic rate_comp_enable_out, mdc, mdio_out, mdio_oe_n_out, st_drv, st_en, mdio_line;
   int n_errors = 0, n_compared = 0;
   row_t rows [14] = '{
      '{5'h00, REG_GLOBAL_CTRL, 16'hFFFF, 16'hD30C}, '{5'h00, REG_GLOBAL_CTRL, 16'h0004, 16'h0004},
      '{5'h00, REG_GLOBAL_CTRL, 16'h0008, 16'h0008}, '{5'h00, REG_GLOBAL_CTRL, 16'h1000, 16'h1000},
      '{5'h01, REG_GLOBAL_CTRL, 16'hFFFF, 16'h1000}, '{5'h00, REG_SPARE, 16'hFFFF, 16'h0000},
      '{5'h00, REG_RSVD_A, 16'hFFFF, 16'h0000}, '{5'h00, REG_RSVD_SA, 16'hFFFF, 16'h0000},
      '{5'h00, REG_RSVD_SB, 16'hFFFF, 16'h0000}, '{5'h00, REG_RSVD_SC, 16'hFFFF, 16'h0000},
      '{5'h00, REG_FACTORY, 16'hFFFF, 16'hFF7F}, '{5'h00, REG_PATTERN, 16'hFFFF, 16'h0000},
      '{5'h00, 5'h0F, 16'hFFFF, 16'h0000}, '{5'h00, REG_LOOP, 16'hA55A, 16'hA55A}};
   idle_row_t idle_rows [3] = '{'{1'b1, 1'b0, D15_2, 1'b1}, '{1'b1, 1'b0, D10_1, 1'b1},
      '{1'b1, 1'b1, D10_1, 1'b0}};
   // resolved mdio line, pulled up when nobody drives
   assign mdio_line = !mdio_oe_n_out ? mdio_out : (st_en ? st_drv : 1'b1);
   mdio_station i_station (.mdc_out(mdc), .mdio_drv_out(st_drv), .mdio_en_out(st_en),
      .mdio_line_in(mdio_line));
   serdes_test_regs i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .por_active_in(por_active_in),
      .mdc_in(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe_n_out(mdio_oe_n_out),
      .phy_addr_in(PHY_ADDR_DEF), .ethernet_mode_pin_in(ethernet_mode_pin_in),
      .busy_pass_pin_in(busy_pass_pin_in), .alt_busy_pin_in(1'b0),
      .pattern_test_pin_in(pattern_test_pin_in), .loopback_pin_in(loopback_pin_in),
      .word_stb_in(word_stb_in), .tx_parallel_bus_in(tx_parallel_bus_in),
      .rx_parallel_bus_out(rx_parallel_bus_out), .rx_parallel_oe_n_out(rx_parallel_oe_n_out),
      .rx_clk_out(rx_clk_out), .rx_serial_word_in(rx_serial_word_in),
      .tx_serial_word_out(tx_serial_word_out), .tx_serial_oe_n_out(tx_serial_oe_n_out),
      .rx_idle_out(rx_idle_out), .rate_comp_enable_out(rate_comp_enable_out),
      .emphasis_level_global_out(emphasis_level_global_out),
      .rx_chan_soft_reset_out(rx_chan_soft_reset_out),
      .tx_chan_soft_reset_out(tx_chan_soft_reset_out));
   initial begin
      forever #20 clk_in = ~clk_in;
   end
   task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] d);
      logic [15:0] unused;
      @(posedge clk_in);
      i_station.frame(1'b0, phy, ra, d, unused);
   endtask
   task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
      logic [15:0] got;
      @(posedge clk_in);
      i_station.frame(1'b1, PHY_ADDR_DEF, ra, 16'h0000, got);
      check("register read", got, exp);
   endtask
   // one word strobe, returns just after the second edge that follows it
   task automatic strobe;
      @(posedge clk_in);
      word_stb_in <= 1'b1;
      @(posedge clk_in);
      word_stb_in <= 1'b0;
      @(posedge clk_in);
      #1;
   endtask
   initial begin
      repeat (100000) @(posedge clk_in);
      n_errors++;
      stop_test();
   end
   initial begin
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      #1;
      check("emphasis reset", emphasis_level_global_out, 2'b11);
      check("rate comp reset", rate_comp_enable_out, 1'b1);
      rd_chk(REG_GLOBAL_CTRL, RST_GLOBAL_CTRL);
      rd_chk(REG_FACTORY, RST_FACTORY);
      rd_chk(REG_SOFT_RESET, 16'h0000);
      rd_chk(REG_PATTERN, 16'h0000);
      rd_chk(REG_LOOP, RST_LOOP);
      $display("test reset values done");
      foreach (rows[i]) begin
         wr(rows[i].phy, rows[i].ra, rows[i].wd);
         rd_chk(rows[i].ra, rows[i].rexp);
         if (rows[i].ra === REG_GLOBAL_CTRL) begin
            check("emphasis", emphasis_level_global_out, rows[i].rexp[3:2]);
            check("rate comp", rate_comp_enable_out, rows[i].rexp[12]);
         end
      end
      wr(PHY_ADDR_DEF, REG_LOOP, 16'h0000);
      $display("test register table done");
      wr(PHY_ADDR_DEF, REG_SOFT_RESET, 16'h8001);
      check("rx soft reset", rx_chan_soft_reset_out, 8'h80);
      check("tx soft reset", tx_chan_soft_reset_out, 8'h01);
      rd_chk(REG_SOFT_RESET, 16'h0000);
      check("soft reset cleared", {rx_chan_soft_reset_out, tx_chan_soft_reset_out}, 0);
      $display("test soft reset done");
      // pattern check with no loop: all-zero input must never pass
      wr(PHY_ADDR_DEF, REG_GLOBAL_CTRL, 16'h0300);
      repeat (30) strobe();
      rd_chk(REG_PATTERN, 16'h0000);
      // serial loopback by pin: looped-back pattern must pass on every lane
      @(posedge clk_in);
      loopback_pin_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      #1;
      check("serial out off", tx_serial_oe_n_out, 8'hFF);
      repeat (30) strobe();
      rd_chk(REG_PATTERN, 16'hFF00);
      @(posedge clk_in);
      loopback_pin_in <= 1'b0;
      wr(PHY_ADDR_DEF, REG_GLOBAL_CTRL, 16'h0000);
      pattern_test_pin_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      for (int i = 0; i < 132; i++) begin
         tx_parallel_bus_in <= {8{i[9:0]}};
         strobe();
         hist[i] = tx_serial_word_out;
      end
      for (int k = 0; k < 5; k++) check("pattern period", hist[k + 127], hist[k]);
      pattern_test_pin_in <= 1'b0;
      $display("test pattern done");
      wr(PHY_ADDR_DEF, REG_LOOP, 16'h0100);
      tx_parallel_bus_in <= {{7{10'h155}}, 10'h2AA};
      rx_serial_word_in <= {8{10'h0F0}};
      strobe();
      check("serial loop data", rx_parallel_bus_out[9:0], 10'h2AA);
      check("serial loop oe", tx_serial_oe_n_out, 8'h01);
      wr(PHY_ADDR_DEF, REG_LOOP, 16'h0003);
      rx_serial_word_in <= {{7{10'h111}}, 10'h0F0, 10'h3C3};
      strobe();
      check("far loop data", tx_serial_word_out[19:0], {10'h0F0, 10'h3C3});
      check("far loop oe", rx_parallel_oe_n_out, 8'h03);
      wr(PHY_ADDR_DEF, REG_LOOP, 16'h0001);
      #1;
      check("half pair oe", rx_parallel_oe_n_out, 8'h00);
      wr(PHY_ADDR_DEF, REG_LOOP, 16'h0000);
      $display("test loopback done");
      @(posedge clk_in);
      por_active_in <= 1'b1;
      word_stb_in <= 1'b1;
      @(posedge clk_in);
      #1;
      check("por clocks", rx_clk_out, 8'h00);
      check("por oe", rx_parallel_oe_n_out, 8'hFF);
      @(posedge clk_in);
      por_active_in <= 1'b0;
      @(posedge clk_in);
      #1;
      check("clocks after por", rx_clk_out, 8'hFF);
      word_stb_in <= 1'b0;
      $display("test power-on reset done");
      foreach (idle_rows[i]) begin
         ethernet_mode_pin_in <= idle_rows[i].ge;
         busy_pass_pin_in <= idle_rows[i].busy;
         rx_serial_word_in <= {8{K28_5_RDN}};
         strobe();
         rx_serial_word_in <= {8{idle_rows[i].w2}};
         strobe();
         check("idle class", rx_idle_out, {8{idle_rows[i].idle}});
      end
      tx_parallel_bus_in <= {8{K28_5_RDN}};
      strobe();
      tx_parallel_bus_in <= {8{D15_2}};
      strobe();
      check("idle substitution", tx_serial_word_out[9:0], D5_6);
      ethernet_mode_pin_in <= 1'b0;
      busy_pass_pin_in <= 1'b0;
      wr(PHY_ADDR_DEF, REG_GLOBAL_CTRL, 16'h8000);
      rx_serial_word_in <= {8{K28_5_RDN}};
      strobe();
      rx_serial_word_in <= {8{D10_1}};
      strobe();
      check("mode by register", rx_idle_out, 8'hFF);
      $display("test idle handling done");
      stop_test();
   end
endmodule
